/* logic/lss_state.sv */
// legacy segment state: window registers, descriptors, fetch address and checks
`timescale 1ns/1ps
`default_nettype none
module lss_state (
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] cur_priv,
   input wire logic legacy_enter,
   input wire logic legacy_exit,
   input wire logic native_wr_en,
   input wire logic [3:0] native_wr_sel,
   input wire logic [63:0] native_wr_data,
   input wire logic [3:0] rd_sel,
   input wire logic legacy_int_wr_en,
   input wire logic [2:0] legacy_int_wr_idx,
   input wire logic [31:0] legacy_int_wr_data,
   input wire logic legacy_flags_wr_en,
   input wire logic [31:0] legacy_flags_wr_data,
   input wire logic fetch_req,
   input wire logic [31:0] code_offset_pointer,
   input wire logic ref_req,
   input wire logic ref_seg,
   input wire logic [31:0] ref_offset,
   input wire logic seg_load_req,
   input wire logic seg_load_seg,
   input wire logic [15:0] seg_load_selector,
   input wire logic [63:0] seg_load_mem_desc,
   output logic [63:0] rd_data_ff,
   output logic legacy_active_ff,
   output logic [63:0] virtual_fetch_address_ff,
   output logic fetch_done_ff,
   output logic default_op32_ff,
   output logic [63:0] ref_address_ff,
   output logic ref_done_ff,
   output logic seg_load_done_ff,
   output logic general_protection_fault_ff,
   output logic stack_segment_exception_ff,
   output logic [63:0] fault_address_ff
);
   logic [63:0] window_ff [lss_pkg::WINDOW_COUNT];
   logic [31:0] arith_system_flags_ff;
   logic [63:0] code_seg_descriptor_ff;
   logic [63:0] stack_seg_descriptor_ff;
   logic [63:0] control_flags_pair_ff;
   logic [63:0] data_seg_selectors_ff;
   logic [63:0] system_seg_selectors_ff;

   logic [63:0] nxt_rd_data;
   logic [63:0] nxt_fetch_addr;
   logic fetch_fault;
   logic [63:0] ref_desc;
   logic [31:0] ref_eff;
   logic ref_fault_gp;
   logic ref_fault_stack;
   logic [63:0] load_desc;
   logic load_fault_gp;
   logic load_fault_stack;
   logic [31:0] nxt_flags_native;
   logic [31:0] nxt_flags_legacy;

   // scaled extent of a register-format descriptor
   function automatic logic [31:0] seg_extent(input logic [63:0] d);
      logic [19:0] lim;
      lim = d[lss_pkg::DESC_LIM_MSB:lss_pkg::DESC_LIM_LSB];
      if (d[lss_pkg::DESC_G_BIT]) begin
         seg_extent = {lim[19:0], 12'h000};
      end else begin
         seg_extent = {12'h000, lim};
      end
   endfunction : seg_extent

   // offset as seen by the segment's address size
   function automatic logic [31:0] seg_offset(input logic [63:0] d, input logic [31:0] off);
      if (d[lss_pkg::DESC_DB_BIT]) begin
         seg_offset = off;
      end else begin
         seg_offset = {16'h0000, off[15:0]};
      end
   endfunction : seg_offset

   // true when the offset lies outside the segment
   function automatic logic seg_out_of_range(input logic [63:0] d, input logic [31:0] off);
      logic expand_down;
      expand_down = !d[lss_pkg::DESC_CODE_BIT] && d[lss_pkg::DESC_EXPDOWN_BIT];
      if (expand_down) begin
         seg_out_of_range = off < seg_extent(d);
      end else begin
         seg_out_of_range = off > seg_extent(d);
      end
   endfunction : seg_out_of_range

   // flags write with privilege-guarded fields held back when not allowed
   function automatic logic [31:0] flags_merge(input logic [31:0] old, input logic [31:0] wr,
                                               input logic [1:0] priv);
      logic [31:0] keep;
      logic [1:0] iopl;
      iopl = old[lss_pkg::FLAG_IOPL_MSB:lss_pkg::FLAG_IOPL_LSB];
      keep = 32'h0000_0000;
      if (priv != lss_pkg::PRIV_ZERO) begin
         keep = keep | lss_pkg::FLAG_PRIV_MASK;
      end
      if (priv > iopl) begin
         keep = keep | lss_pkg::FLAG_IOPL_MASK;
      end
      flags_merge = (old & keep) | (wr & ~keep);
   endfunction : flags_merge

   // window registers: native writes take all 64 bits, legacy writes the low half
   for (genvar gi = 0; gi < lss_pkg::WINDOW_COUNT; gi++) begin : g_window
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            window_ff[gi] <= lss_pkg::REG64_RESET;
         end else if (native_wr_en && native_wr_sel == (lss_pkg::SEL_WINDOW_BASE + 4'(gi))) begin
            window_ff[gi] <= native_wr_data;
         end else if (legacy_active_ff && legacy_exit) begin
            // a write in the exit cycle still lands before the extension
            if (legacy_int_wr_en && legacy_int_wr_idx == 3'(gi)) begin
               window_ff[gi] <= {{32{legacy_int_wr_data[lss_pkg::SIGN_BIT]}}, legacy_int_wr_data};
            end else begin
               window_ff[gi] <= {{32{window_ff[gi][lss_pkg::SIGN_BIT]}}, window_ff[gi][31:0]};
            end
         end else if (legacy_active_ff && legacy_int_wr_en && legacy_int_wr_idx == 3'(gi)) begin
            // upper half is don't-care while legacy runs, so it is left alone
            window_ff[gi] <= {window_ff[gi][63:32], legacy_int_wr_data};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         legacy_active_ff <= 1'b0;
      end else if (legacy_exit) begin
         legacy_active_ff <= 1'b0;
      end else if (legacy_enter) begin
         legacy_active_ff <= 1'b1;
      end
   end

   always_comb begin
      nxt_flags_native = flags_merge(arith_system_flags_ff, native_wr_data[31:0], cur_priv);
      nxt_flags_legacy = flags_merge(arith_system_flags_ff, legacy_flags_wr_data, cur_priv);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         arith_system_flags_ff <= lss_pkg::FLAGS_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_FLAGS) begin
         arith_system_flags_ff <= nxt_flags_native;
      end else if (legacy_active_ff && legacy_flags_wr_en) begin
         arith_system_flags_ff <= nxt_flags_legacy;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         control_flags_pair_ff <= lss_pkg::REG64_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_CTRL_PAIR && cur_priv == lss_pkg::PRIV_ZERO) begin
         control_flags_pair_ff <= native_wr_data;
      end
   end

   // legacy segment load: unscramble memory format and check it
   always_comb begin
      load_desc = lss_pkg::REG64_RESET;
      load_desc[31:0] = {seg_load_mem_desc[63:lss_pkg::MEM_BASE_HI_LSB],
                         seg_load_mem_desc[lss_pkg::MEM_BASE_LO_MSB:lss_pkg::MEM_BASE_LO_LSB]};
      load_desc[lss_pkg::DESC_LIM_MSB:lss_pkg::DESC_LIM_LSB] =
         {seg_load_mem_desc[lss_pkg::MEM_LIM_HI_MSB:lss_pkg::MEM_LIM_HI_LSB],
          seg_load_mem_desc[lss_pkg::MEM_LIM_LO_MSB:0]};
      load_desc[lss_pkg::DESC_TYPE_MSB:lss_pkg::DESC_TYPE_LSB] =
         seg_load_mem_desc[lss_pkg::MEM_TYPE_MSB:lss_pkg::MEM_TYPE_LSB];
      load_desc[lss_pkg::DESC_ACCESSED_BIT] = 1'b1;
      load_desc[lss_pkg::DESC_S_BIT] = seg_load_mem_desc[lss_pkg::MEM_S_BIT];
      load_desc[lss_pkg::DESC_DPL_MSB:lss_pkg::DESC_DPL_LSB] =
         seg_load_mem_desc[lss_pkg::MEM_DPL_MSB:lss_pkg::MEM_DPL_LSB];
      load_desc[lss_pkg::DESC_P_BIT] = seg_load_mem_desc[lss_pkg::MEM_P_BIT];
      load_desc[lss_pkg::DESC_AV_BIT] = seg_load_mem_desc[lss_pkg::MEM_AV_BIT];
      load_desc[lss_pkg::DESC_LG_BIT] = seg_load_mem_desc[lss_pkg::MEM_LG_BIT];
      load_desc[lss_pkg::DESC_DB_BIT] = seg_load_mem_desc[lss_pkg::MEM_DB_BIT];
      load_desc[lss_pkg::DESC_G_BIT] = seg_load_mem_desc[lss_pkg::MEM_G_BIT];
      // a system descriptor or privilege mismatch is refused outright
      load_fault_gp = !load_desc[lss_pkg::DESC_S_BIT];
      if (seg_load_seg == lss_pkg::SEG_STACK) begin
         if (load_desc[lss_pkg::DESC_DPL_MSB:lss_pkg::DESC_DPL_LSB] != cur_priv) begin
            load_fault_gp = 1'b1;
         end
      end else if (load_desc[lss_pkg::DESC_DPL_MSB:lss_pkg::DESC_DPL_LSB] < cur_priv
                   && load_desc[lss_pkg::DESC_CODE_BIT]) begin
         load_fault_gp = 1'b1;
      end
      load_fault_stack = !load_fault_gp && !load_desc[lss_pkg::DESC_P_BIT]
                         && seg_load_seg == lss_pkg::SEG_STACK;
      if (!load_fault_gp && !load_desc[lss_pkg::DESC_P_BIT] && seg_load_seg == lss_pkg::SEG_CODE) begin
         load_fault_gp = 1'b1;
      end
   end

   // native writes store raw, unchecked; no table is touched
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         code_seg_descriptor_ff <= lss_pkg::REG64_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_CODE_DESC) begin
         code_seg_descriptor_ff <= native_wr_data;
      end else if (legacy_active_ff && seg_load_req && seg_load_seg == lss_pkg::SEG_CODE
                   && !load_fault_gp) begin
         code_seg_descriptor_ff <= load_desc;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stack_seg_descriptor_ff <= lss_pkg::REG64_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_STACK_DESC) begin
         stack_seg_descriptor_ff <= native_wr_data;
      end else if (legacy_active_ff && seg_load_req && seg_load_seg == lss_pkg::SEG_STACK
                   && !load_fault_gp && !load_fault_stack) begin
         stack_seg_descriptor_ff <= load_desc;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_seg_selectors_ff <= lss_pkg::REG64_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_DATA_SELS) begin
         data_seg_selectors_ff <= native_wr_data;
      end
   end

   // code selector in 15:0, stack selector in 31:16
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         system_seg_selectors_ff <= lss_pkg::REG64_RESET;
      end else if (native_wr_en && native_wr_sel == lss_pkg::SEL_SYS_SELS) begin
         system_seg_selectors_ff <= native_wr_data;
      end else if (legacy_active_ff && seg_load_req && !load_fault_gp && !load_fault_stack) begin
         if (seg_load_seg == lss_pkg::SEG_CODE) begin
            system_seg_selectors_ff[15:0] <= seg_load_selector;
         end else begin
            system_seg_selectors_ff[31:16] <= seg_load_selector;
         end
      end
   end

   // fetch address: 32-bit add wraps naturally at 4 GB
   always_comb begin
      nxt_fetch_addr = {lss_pkg::WORD_ZERO,
                        seg_offset(code_seg_descriptor_ff, code_offset_pointer)
                        + code_seg_descriptor_ff[31:0]};
      fetch_fault = seg_out_of_range(code_seg_descriptor_ff,
                                     seg_offset(code_seg_descriptor_ff, code_offset_pointer));
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         virtual_fetch_address_ff <= lss_pkg::REG64_RESET;
         fetch_done_ff <= 1'b0;
      end else begin
         fetch_done_ff <= legacy_active_ff && fetch_req;
         if (legacy_active_ff && fetch_req) begin
            virtual_fetch_address_ff <= nxt_fetch_addr;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         default_op32_ff <= 1'b0;
      end else begin
         default_op32_ff <= code_seg_descriptor_ff[lss_pkg::DESC_DB_BIT];
      end
   end

   // data reference checks through the chosen segment
   always_comb begin
      ref_desc = (ref_seg == lss_pkg::SEG_STACK) ? stack_seg_descriptor_ff : code_seg_descriptor_ff;
      ref_eff = seg_offset(ref_desc, ref_offset);
      ref_fault_gp = 1'b0;
      ref_fault_stack = 1'b0;
      if (!ref_desc[lss_pkg::DESC_P_BIT]) begin
         if (ref_seg == lss_pkg::SEG_STACK) begin
            ref_fault_stack = 1'b1;
         end else begin
            ref_fault_gp = 1'b1;
         end
      end else if (ref_desc[lss_pkg::DESC_DPL_MSB:lss_pkg::DESC_DPL_LSB] < cur_priv) begin
         ref_fault_gp = 1'b1;
      end else if (seg_out_of_range(ref_desc, ref_eff)) begin
         if (ref_seg == lss_pkg::SEG_STACK) begin
            ref_fault_stack = 1'b1;
         end else begin
            ref_fault_gp = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ref_address_ff <= lss_pkg::REG64_RESET;
         ref_done_ff <= 1'b0;
      end else begin
         ref_done_ff <= legacy_active_ff && ref_req;
         if (legacy_active_ff && ref_req) begin
            ref_address_ff <= {lss_pkg::WORD_ZERO, ref_eff + ref_desc[31:0]};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         seg_load_done_ff <= 1'b0;
      end else begin
         seg_load_done_ff <= legacy_active_ff && seg_load_req;
      end
   end

   // fault reporting: fetch fault uses its own address, others the last fetch
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         general_protection_fault_ff <= 1'b0;
         stack_segment_exception_ff <= 1'b0;
         fault_address_ff <= lss_pkg::REG64_RESET;
      end else begin
         general_protection_fault_ff <= legacy_active_ff
            && ((fetch_req && fetch_fault) || (ref_req && ref_fault_gp)
                || (seg_load_req && load_fault_gp));
         stack_segment_exception_ff <= legacy_active_ff
            && ((ref_req && ref_fault_stack) || (seg_load_req && load_fault_stack));
         if (legacy_active_ff && fetch_req && fetch_fault) begin
            fault_address_ff <= nxt_fetch_addr;
         end else if (legacy_active_ff && ((ref_req && (ref_fault_gp || ref_fault_stack))
                      || (seg_load_req && (load_fault_gp || load_fault_stack)))) begin
            fault_address_ff <= virtual_fetch_address_ff;
         end
      end
   end

   always_comb begin
      case (rd_sel)
         lss_pkg::SEL_FLAGS: nxt_rd_data = {lss_pkg::WORD_ZERO, arith_system_flags_ff};
         lss_pkg::SEL_CODE_DESC: nxt_rd_data = code_seg_descriptor_ff;
         lss_pkg::SEL_STACK_DESC: nxt_rd_data = stack_seg_descriptor_ff;
         lss_pkg::SEL_CTRL_PAIR: nxt_rd_data = control_flags_pair_ff;
         lss_pkg::SEL_DATA_SELS: nxt_rd_data = data_seg_selectors_ff;
         lss_pkg::SEL_SYS_SELS: nxt_rd_data = system_seg_selectors_ff;
         default: begin
            if (rd_sel[3]) begin
               nxt_rd_data = window_ff[rd_sel[2:0]];
            end else begin
               nxt_rd_data = lss_pkg::REG64_RESET;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_data_ff <= lss_pkg::REG64_RESET;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end
endmodule : lss_state
`default_nettype wire

/* logic/lss_pkg.sv */
// constants, register map and field layout for the legacy segment state block
// Overview of operation
// - legacy integer registers live in low 32 bits of window registers 8-15
// - upper 32 bits of window registers are ignored on legacy entry
// - on legacy exit upper 32 bits become copies of bit 31
// - fetch address is zero upper half, offset plus code segment start below
// - fetch address is recomputed on every legacy instruction fetch
// - fetch offset beyond code segment limit raises general protection fault
// - instruction addresses above 4 GB wrap modulo 4 GB
// - selector registers hold 16-bit selectors, first in bits 15:0
// - segment start is descriptor bits 31:0, zero-extended as origin
// - extent is bits 51:32, maximum offset for expand-up segments
// - for expand-down segments extent is the minimum valid offset
// - granularity scaling shifts extent left by 12
// - kind code sits in bits 55:52, accessed indicator bit 52
// - bit 56 set marks code or data segment, clear marks system
// - descriptor privilege bits 58:57 checked on every legacy reference
// - present bit 59 clear faults: protection for code/data, stack for stack
// - native writes to descriptors are not checked
// - no table coherency and no table accessed updates on native loads
// - legacy segment loads are checked and unscrambled into register format
// - control pair is one 64-bit register, written only at privilege zero
// - flags register writes of some bits depend on privilege and I/O level
// - scaling applies only when granularity bit 63 is one
// - bit 62 clear truncates offsets to 16 bits, set gives 32-bit offsets
package lss_pkg;
   // register selects of the native access port
   localparam logic [3:0] SEL_FLAGS = 4'h0;
   localparam logic [3:0] SEL_CODE_DESC = 4'h1;
   localparam logic [3:0] SEL_STACK_DESC = 4'h2;
   localparam logic [3:0] SEL_CTRL_PAIR = 4'h3;
   localparam logic [3:0] SEL_DATA_SELS = 4'h4;
   localparam logic [3:0] SEL_SYS_SELS = 4'h5;
   localparam logic [3:0] SEL_WINDOW_BASE = 4'h8;
   localparam int WINDOW_COUNT = 8;
   // register format descriptor fields
   localparam int DESC_BASE_LSB = 0;
   localparam int DESC_LIM_LSB = 32;
   localparam int DESC_LIM_MSB = 51;
   localparam int DESC_TYPE_LSB = 52;
   localparam int DESC_TYPE_MSB = 55;
   localparam int DESC_ACCESSED_BIT = 52;
   localparam int DESC_EXPDOWN_BIT = 54;
   localparam int DESC_CODE_BIT = 55;
   localparam int DESC_S_BIT = 56;
   localparam int DESC_DPL_LSB = 57;
   localparam int DESC_DPL_MSB = 58;
   localparam int DESC_P_BIT = 59;
   localparam int DESC_AV_BIT = 60;
   localparam int DESC_LG_BIT = 61;
   localparam int DESC_DB_BIT = 62;
   localparam int DESC_G_BIT = 63;
   localparam int GRAN_SHIFT = 12;
   localparam int SIGN_BIT = 31;
   // memory (scrambled) descriptor fields
   localparam int MEM_LIM_LO_MSB = 15;
   localparam int MEM_BASE_LO_LSB = 16;
   localparam int MEM_BASE_LO_MSB = 39;
   localparam int MEM_TYPE_LSB = 40;
   localparam int MEM_TYPE_MSB = 43;
   localparam int MEM_S_BIT = 44;
   localparam int MEM_DPL_LSB = 45;
   localparam int MEM_DPL_MSB = 46;
   localparam int MEM_P_BIT = 47;
   localparam int MEM_LIM_HI_LSB = 48;
   localparam int MEM_LIM_HI_MSB = 51;
   localparam int MEM_AV_BIT = 52;
   localparam int MEM_LG_BIT = 53;
   localparam int MEM_DB_BIT = 54;
   localparam int MEM_G_BIT = 55;
   localparam int MEM_BASE_HI_LSB = 56;
   // flags bits guarded by privilege
   localparam int FLAG_IF_BIT = 9;
   localparam int FLAG_IOPL_LSB = 12;
   localparam int FLAG_IOPL_MSB = 13;
   localparam logic [31:0] FLAG_PRIV_MASK = 32'h0000_3000;
   localparam logic [31:0] FLAG_IOPL_MASK = 32'h0000_0200;
   // reset values
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
   localparam logic [63:0] REG64_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] PRIV_ZERO = 2'h0;
   // segment choice for memory references and legacy loads
   localparam logic SEG_CODE = 1'b0;
   localparam logic SEG_STACK = 1'b1;
endpackage : lss_pkg

/* bench/lss_state_asserts.sv */
// port-level checks for the legacy segment state block
`timescale 1ns/1ps
`default_nettype none
module lss_state_asserts (
   input wire logic clock,
   input wire logic reset,
   input wire logic legacy_enter,
   input wire logic legacy_exit,
   input wire logic fetch_req,
   input wire logic ref_req,
   input wire logic seg_load_req,
   input wire logic legacy_active_ff,
   input wire logic [63:0] virtual_fetch_address_ff,
   input wire logic fetch_done_ff,
   input wire logic [63:0] ref_address_ff,
   input wire logic ref_done_ff,
   input wire logic seg_load_done_ff,
   input wire logic general_protection_fault_ff,
   input wire logic stack_segment_exception_ff,
   input wire logic [63:0] fault_address_ff
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   chk_enter_sets_active: assert property (legacy_enter && !legacy_exit |=> legacy_active_ff)
      else $error("legacy entry not taken");
   chk_exit_clears_active: assert property (legacy_exit |=> !legacy_active_ff)
      else $error("legacy exit not taken");
   chk_fetch_answers: assert property (fetch_req && legacy_active_ff |=> fetch_done_ff)
      else $error("fetch not answered");
   chk_fetch_no_spurious: assert property (!(fetch_req && legacy_active_ff) |=> !fetch_done_ff)
      else $error("fetch done without request");
   chk_fetch_upper_zero: assert property (fetch_done_ff |-> virtual_fetch_address_ff[63:32] == 32'h0000_0000)
      else $error("fetch address upper half not zero");
   chk_ref_upper_zero: assert property (ref_done_ff |-> ref_address_ff[63:32] == 32'h0000_0000)
      else $error("reference address upper half not zero");
   chk_ref_answers: assert property (ref_req && legacy_active_ff |=> ref_done_ff)
      else $error("reference not answered");
   chk_load_answers: assert property (seg_load_req && legacy_active_ff |=> seg_load_done_ff)
      else $error("segment load not answered");
   chk_fault_has_cause: assert property (general_protection_fault_ff
      |-> fetch_done_ff || ref_done_ff || seg_load_done_ff)
      else $error("protection fault without operation");
   chk_stack_fault_cause: assert property (stack_segment_exception_ff |-> ref_done_ff || seg_load_done_ff)
      else $error("stack exception without reference or load");
   chk_fetch_fault_addr: assert property (general_protection_fault_ff && fetch_done_ff
      |-> fault_address_ff == virtual_fetch_address_ff)
      else $error("fetch fault address mismatch");
   cov_fetch_fault: cover property (fetch_done_ff && general_protection_fault_ff);
   cov_stack_fault: cover property (ref_done_ff && stack_segment_exception_ff);
   cov_load_ok: cover property (seg_load_done_ff && !general_protection_fault_ff);
endmodule : lss_state_asserts
`default_nettype wire

/* bench/lss_state_test.sv */
// self-checking bench for the legacy segment state block
`timescale 1ns/1ps
`default_nettype none
module lss_state_test;
   logic clock, reset, legacy_enter, legacy_exit, native_wr_en, legacy_int_wr_en, legacy_flags_wr_en;
   logic fetch_req, ref_req, ref_seg, seg_load_req, seg_load_seg, legacy_active_ff, fetch_done_ff;
   logic default_op32_ff, ref_done_ff, seg_load_done_ff, general_protection_fault_ff, stack_segment_exception_ff;
   logic [1:0] cur_priv;
   logic [2:0] legacy_int_wr_idx;
   logic [3:0] native_wr_sel, rd_sel;
   logic [15:0] seg_load_selector;
   logic [31:0] legacy_int_wr_data, legacy_flags_wr_data, code_offset_pointer, ref_offset;
   logic [63:0] native_wr_data, seg_load_mem_desc, rd_data_ff, virtual_fetch_address_ff, ref_address_ff;
   logic [63:0] fault_address_ff;
   int n_errors = 0;
   int tests_run = 0;
   lss_state lss_state_inst (.*);
   task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wr(input logic [3:0] sel, input logic [63:0] data);
      native_wr_en = 1'h1;
      native_wr_sel = sel;
      native_wr_data = data;
      @(negedge clock);
      native_wr_en = 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] sel, input logic [63:0] exp);
      rd_sel = sel;
      @(negedge clock);
      check("rd_data_ff", rd_data_ff, exp);
   endtask : rd
   task automatic fetch(input logic [31:0] off, input logic [63:0] addr, input logic gp);
      fetch_req = 1'h1;
      code_offset_pointer = off;
      @(negedge clock);
      fetch_req = 1'h0;
      check("fetch address", virtual_fetch_address_ff, addr);
      check("fetch fault", general_protection_fault_ff, gp);
   endtask : fetch
   // flt is {protection, stack}
   task automatic mref(input logic seg, input logic [31:0] off, input logic [63:0] addr, input logic [1:0] flt);
      ref_req = 1'h1;
      ref_seg = seg;
      ref_offset = off;
      @(negedge clock);
      ref_req = 1'h0;
      if (flt == 2'h0) check("ref address", ref_address_ff, addr);
      check("ref faults", {general_protection_fault_ff, stack_segment_exception_ff}, flt);
   endtask : mref
   task automatic load(input logic [15:0] sel, input logic [63:0] mem, input logic [1:0] flt);
      seg_load_req = 1'h1;
      seg_load_selector = sel;
      seg_load_mem_desc = mem;
      @(negedge clock);
      seg_load_req = 1'h0;
      check("load faults", {general_protection_fault_ff, stack_segment_exception_ff}, flt);
   endtask : load
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   // run is about 57 cycles, so this only trips on a hang
   initial begin
      repeat (1000) @(posedge clock);
      n_errors++;
      end_of_test();
   end
   initial begin
      {legacy_enter, legacy_exit, native_wr_en, legacy_int_wr_en, legacy_flags_wr_en} = 5'h00;
      {fetch_req, ref_req, ref_seg, seg_load_req, seg_load_seg, cur_priv} = 7'h00;
      {legacy_int_wr_idx, native_wr_sel, rd_sel, seg_load_selector} = 27'h000_0000;
      {legacy_int_wr_data, legacy_flags_wr_data, code_offset_pointer, ref_offset} = 128'h0;
      {native_wr_data, seg_load_mem_desc} = 128'h0;
      reset = 1'h1;
      repeat (6) @(negedge clock);
      reset = 1'h0;
      rd(4'h0, 64'h0000_0000_0000_0002);
      rd(4'h1, 64'h0000_0000_0000_0000);
      cur_priv = 2'h1;
      wr(4'h3, 64'h8000_0011_0000_0600);
      rd(4'h3, 64'h0000_0000_0000_0000);
      cur_priv = 2'h0;
      wr(4'h3, 64'h8000_0011_0000_0600);
      rd(4'h3, 64'h8000_0011_0000_0600);
      cur_priv = 2'h3;
      wr(4'h0, 64'h0000_0000_FFFF_FFFF);
      rd(4'h0, 64'h0000_0000_FFFF_CDFF);
      wr(4'h2, 64'h0123_4567_89AB_CDEF);
      rd(4'h2, 64'h0123_4567_89AB_CDEF);
      wr(4'h5, 64'h5555_6666_7777_8888);
      rd(4'h5, 64'h5555_6666_7777_8888);
      wr(4'h8, 64'hAAAA_BBBB_1234_5678);
      wr(4'h9, 64'hCCCC_DDDD_0000_0000);
      wr(4'hA, 64'h1234_5678_9ABC_DEF0);
      legacy_enter = 1'h1;
      @(negedge clock);
      legacy_enter = 1'h0;
      legacy_int_wr_en = 1'h1;
      legacy_int_wr_data = 32'h8000_0000;
      @(negedge clock);
      legacy_int_wr_idx = 3'h1;
      legacy_int_wr_data = 32'h7FFF_FFFF;
      @(negedge clock);
      legacy_int_wr_en = 1'h0;
      rd(4'h8, 64'hAAAA_BBBB_8000_0000);
      legacy_flags_wr_en = 1'h1;
      legacy_flags_wr_data = 32'h0000_3203;
      @(negedge clock);
      legacy_flags_wr_en = 1'h0;
      rd(4'h0, 64'h0000_0000_0000_0003);
      wr(4'h1, 64'h49B0_1000_F000_0000);
      fetch(32'h0000_1000, 64'h0000_0000_F000_1000, 1'h0);
      check("op size", default_op32_ff, 1'h1);
      fetch(32'h0000_1001, 64'h0000_0000_F000_1001, 1'h1);
      check("fault address", fault_address_ff, 64'h0000_0000_F000_1001);
      wr(4'h1, 64'hC9BF_FFFF_F000_0000);
      fetch(32'h2000_0000, 64'h0000_0000_1000_0000, 1'h0);
      fetch(32'hFFFF_F000, 64'h0000_0000_EFFF_F000, 1'h0);
      fetch(32'hFFFF_F001, 64'h0000_0000_EFFF_F001, 1'h1);
      wr(4'h1, 64'h09B0_1000_F000_0000);
      fetch(32'h0001_0005, 64'h0000_0000_F000_0005, 1'h0);
      check("op size", default_op32_ff, 1'h0);
      wr(4'h2, 64'h4730_0100_0001_0000);
      mref(1'h1, 32'h0000_0010, 64'h0, 2'h1);
      wr(4'h1, 64'h41B0_1000_F000_0000);
      mref(1'h0, 32'h0000_0010, 64'h0, 2'h2);
      wr(4'h2, 64'h4930_0100_0001_0000);
      mref(1'h1, 32'h0000_0010, 64'h0, 2'h2);
      wr(4'h2, 64'h4F30_0100_0001_0000);
      mref(1'h1, 32'h0000_0100, 64'h0000_0000_0001_0100, 2'h0);
      mref(1'h1, 32'h0000_0101, 64'h0, 2'h1);
      wr(4'h2, 64'h4F70_0100_0001_0000);
      mref(1'h1, 32'h0000_00FF, 64'h0, 2'h1);
      mref(1'h1, 32'h0000_0100, 64'h0000_0000_0001_0100, 2'h0);
      seg_load_seg = 1'h1;
      load(16'h002B, 64'h124A_F234_5678_BCDE, 2'h0);
      rd(4'h2, 64'h4F3A_BCDE_1234_5678);
      rd(4'h5, 64'h5555_6666_002B_8888);
      seg_load_seg = 1'h0;
      load(16'h0033, 64'h124A_E234_5678_BCDE, 2'h2);
      rd(4'h1, 64'h41B0_1000_F000_0000);
      legacy_exit = 1'h1;
      @(negedge clock);
      legacy_exit = 1'h0;
      rd(4'h8, 64'hFFFF_FFFF_8000_0000);
      rd(4'h9, 64'h0000_0000_7FFF_FFFF);
      rd(4'hA, 64'hFFFF_FFFF_9ABC_DEF0);
      end_of_test();
   end
endmodule : lss_state_test
bind lss_state lss_state_asserts lss_state_asserts_inst (.clock, .reset, .legacy_enter, .legacy_exit, .fetch_req,
   .ref_req, .seg_load_req, .legacy_active_ff, .virtual_fetch_address_ff, .fetch_done_ff, .ref_address_ff,
   .ref_done_ff, .seg_load_done_ff, .general_protection_fault_ff, .stack_segment_exception_ff, .fault_address_ff);
`default_nettype wire
